// ---- hw/pta_top.sv ----
// product-term macrocell array: 16 macrocells fed by 32 fabric inputs and
// 9 feedbacks, configured and observed over AXI4-Lite
// assumes fabricIn is on the system clock; clock, enable, clear and chip
// reset inputs are asynchronous and are resampled before use
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pta_defs.svh"
module pta_top #(
  parameter int MEM_DEPTH = 128
) (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   rstn,
  // axi4-lite write address and data
  input  wire logic [`PTA_AW-1:0]     s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire pta_pkg::pta_word_t     s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // axi4-lite read
  input  wire logic [`PTA_AW-1:0]     s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output pta_pkg::pta_word_t          s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // fabric side
  input  wire logic [31:0]            fabricIn,
  input  wire logic [3:0]             dedicatedClock,
  input  wire logic [3:0]             globalSignal,
  input  wire logic                   localClockA,
  input  wire logic                   localClockB,
  input  wire logic                   blockClockEnableA,
  input  wire logic                   blockClockEnableB,
  input  wire logic                   localClearA,
  input  wire logic                   localClearB,
  input  wire logic                   chipWideResetN,
  output logic [15:0]                 macroOut
);
  import pta_pkg::*;

  // ---- configuration state
  pta_word_t            ctrl_r;
  pta_word_t            mcCfg_r [16];
  logic [15:0]          macroOut_r;
  logic [MEM_DEPTH*32-1:0] cfgWords;
  pta_word_t            memRdData;

  // ---- bus state
  logic                 awready_r;
  logic                 wready_r;
  logic                 awHeld_r;
  logic                 wHeld_r;
  logic [`PTA_AW-1:0]   awAddr_r;
  pta_word_t            wData_r;
  logic [3:0]           wStrb_r;
  logic                 bvalid_r;
  logic [1:0]           bresp_r;
  logic                 arready_r;
  logic                 rdStage_r;
  pta_area_e            rdArea_r;
  logic [3:0]           rdIdx_r;
  pta_word_t            rdata_r;
  logic [1:0]           rresp_r;
  logic                 rvalid_r;

  function automatic pta_area_e areaOf(input logic [`PTA_AW-1:0] a);
    pta_area_e r;
    r = PTA_AREA_NONE;
    if ({a[`PTA_AW-1:2], 2'h0} == `PTA_CTRL_OFS) begin
      r = PTA_AREA_CTRL;
    end else if ({a[`PTA_AW-1:2], 2'h0} == `PTA_STAT_OFS) begin
      r = PTA_AREA_STAT;
    end else if ((a & `PTA_MCCFG_MASK) == `PTA_MCCFG_BASE) begin
      r = PTA_AREA_MC;
    end else if ((a & `PTA_PTMEM_MASK) == `PTA_PTMEM_BASE) begin
      r = PTA_AREA_MEM;
    end
    areaOf = r;
  endfunction : areaOf

  function automatic pta_word_t mergeStrb(input pta_word_t old, input pta_word_t nw,
                                          input logic [3:0] strb, input pta_word_t wmask);
    pta_word_t r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    mergeStrb = r & wmask;
  endfunction : mergeStrb

  // source codes: 0..3 dedicated pins, 4..7 global signals, 8 local routing
  function automatic logic pickClock(input logic [3:0] code, input logic [3:0] ded,
                                     input logic [3:0] glob, input logic loc);
    logic r;
    r = 1'h0;
    if (code < 4'h4) begin
      r = ded[code[1:0]];
    end else if (code < 4'h8) begin
      r = glob[code[1:0]];
    end else if (code == 4'h8) begin
      r = loc;
    end
    pickClock = r;
  endfunction : pickClock

  // source codes: 0..3 global signals, 4 local routing, others clear only when inverted
  function automatic logic pickClear(input logic [2:0] code, input logic [3:0] glob,
                                     input logic loc, input logic inv);
    logic r;
    r = 1'h0;
    if (code < 3'h4) begin
      r = glob[code[1:0]];
    end else if (code == 3'h4) begin
      r = loc;
    end
    pickClear = r ^ inv;
  endfunction : pickClear

  // a term with no literal selected is held low, so unloaded terms add nothing
  function automatic logic ptEval(input logic [40:0] inp, input pta_word_t trueLo,
                                  input pta_word_t compLo, input pta_word_t hi);
    logic [40:0] tm;
    logic [40:0] cm;
    tm = {hi[8:0], trueLo};
    cm = {hi[24:16], compLo};
    ptEval = (|(tm | cm)) && ((inp & tm) == tm) && ((~inp & cm) == cm);
  endfunction : ptEval

  // ---- asynchronous inputs, two flip-flops each
  logic [14:0] syncMeta_r;
  logic [14:0] sync_r;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      syncMeta_r <= `PTA_SYNC_RST;
      sync_r     <= `PTA_SYNC_RST;
    end else begin
      syncMeta_r <= {chipWideResetN, localClearB, localClearA, blockClockEnableB,
                     blockClockEnableA, localClockB, localClockA, globalSignal,
                     dedicatedClock};
      sync_r     <= syncMeta_r;
    end
  end

  logic clkA;
  logic clkB;
  logic clkAPrev_r;
  logic clkBPrev_r;
  logic tickA;
  logic tickB;
  logic clrA;
  logic clrB;
  logic chipClr;
  logic modeOn;

  assign modeOn = ctrl_r[`PTA_CTRL_MODE];
  assign clkA = pickClock(ctrl_r[`PTA_CTRL_CLKSRCA +: 4], sync_r[3:0], sync_r[7:4],
                          sync_r[8]);
  assign clkB = pickClock(ctrl_r[`PTA_CTRL_CLKSRCB +: 4], sync_r[3:0], sync_r[7:4],
                          sync_r[9]);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      clkAPrev_r <= 1'h0;
      clkBPrev_r <= 1'h0;
    end else begin
      clkAPrev_r <= clkA;
      clkBPrev_r <= clkB;
    end
  end

  // each block clock has its own edge, so a block can mix rising and falling
  assign tickA = (ctrl_r[`PTA_CTRL_FALLA] ? (clkAPrev_r & ~clkA) : (~clkAPrev_r & clkA))
                 & sync_r[10];
  assign tickB = (ctrl_r[`PTA_CTRL_FALLB] ? (clkBPrev_r & ~clkB) : (~clkBPrev_r & clkB))
                 & sync_r[11];
  assign clrA = pickClear(ctrl_r[`PTA_CTRL_CLRSRCA +: 3], sync_r[7:4], sync_r[12],
                          ctrl_r[`PTA_CTRL_INVCLRA]);
  assign clrB = pickClear(ctrl_r[`PTA_CTRL_CLRSRCB +: 3], sync_r[7:4], sync_r[13],
                          ctrl_r[`PTA_CTRL_INVCLRB]);
  assign chipClr = ctrl_r[`PTA_CTRL_RSTEN] & ~sync_r[14];

  // ---- logic array
  logic [40:0] arrayIn;
  logic [31:0] ptVal;
  // feedback is taken after the output flop so combinational macrocells cannot loop
  assign arrayIn = {macroOut_r[8:0], fabricIn};

  always_comb begin
    for (int p = 0; p < 32; p++) begin
      ptVal[p] = ptEval(arrayIn, cfgWords[(p*4)*32 +: 32], cfgWords[(p*4+1)*32 +: 32],
                        cfgWords[(p*4+2)*32 +: 32]);
    end
  end

  // ---- select matrix and expander chain
  logic [15:0] primary;
  logic [15:0] secondary;
  logic [15:0] expOut;
  logic [15:0] mcTick;
  logic [15:0] mcClear;
  logic [15:0] regQ;

  always_comb begin
    logic carry;
    logic pt0;
    logic pt1;
    logic lend0;
    logic lend1;
    logic split;
    logic chainIn;
    carry = 1'h0;
    pt0 = 1'h0;
    pt1 = 1'h0;
    lend0 = 1'h0;
    lend1 = 1'h0;
    split = 1'h0;
    chainIn = 1'h0;
    for (int i = 0; i < 16; i++) begin
      pt0 = ptVal[2*i];
      pt1 = ptVal[2*i+1] ^ mcCfg_r[i][`PTA_MC_INVPT1];
      lend0 = mcCfg_r[i][`PTA_MC_EXP0];
      lend1 = mcCfg_r[i][`PTA_MC_EXP1];
      split = mcCfg_r[i][`PTA_MC_KIND + 1];
      chainIn = mcCfg_r[i][`PTA_MC_CHAIN] & carry;
      // a lending macrocell passes the chain on instead of absorbing it
      expOut[i] = (lend0 & pt0) | (lend1 & pt1) | ((lend0 | lend1) & chainIn);
      primary[i] = (~lend0 & pt0) | (~lend1 & ~split & pt1)
                   | (~(lend0 | lend1) & chainIn);
      secondary[i] = ~lend1 & split & pt1;
      carry = expOut[i];
      mcTick[i] = mcCfg_r[i][`PTA_MC_CLKB] ? tickB : tickA;
      mcClear[i] = chipClr | ~modeOn
                   | ((mcCfg_r[i][`PTA_MC_CLRSEL +: 2] == 2'h1) & clrA)
                   | ((mcCfg_r[i][`PTA_MC_CLRSEL +: 2] == 2'h2) & clrB);
    end
  end

  for (genvar g = 0; g < 16; g++) begin : g_mc
    pta_mc_reg u_reg (
      .clock     (clock),
      .rstn      (rstn),
      .tick      (mcTick[g]),
      .kind      (pta_kind_e'(mcCfg_r[g][`PTA_MC_KIND +: 2])),
      .clear     (mcClear[g]),
      .primary   (primary[g]),
      .secondary (secondary[g]),
      .q         (regQ[g])
    );
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      macroOut_r <= '0;
    end else begin
      for (int i = 0; i < 16; i++) begin
        macroOut_r[i] <= modeOn & (mcCfg_r[i][`PTA_MC_SEQ] ? regQ[i] : primary[i]);
      end
    end
  end

  // ---- axi4-lite write path
  logic doWrite;
  pta_area_e wrArea;
  assign wrArea = areaOf(awAddr_r);
  assign doWrite = awHeld_r & wHeld_r & ~bvalid_r;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      awready_r <= 1'h1;
      awHeld_r  <= 1'h0;
      awAddr_r  <= '0;
    end else if (s_axi_awvalid & awready_r) begin
      awready_r <= 1'h0;
      awHeld_r  <= 1'h1;
      awAddr_r  <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld_r  <= 1'h0;
    end else if (bvalid_r & s_axi_bready) begin
      awready_r <= 1'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      wready_r <= 1'h1;
      wHeld_r  <= 1'h0;
      wData_r  <= '0;
      wStrb_r  <= '0;
    end else if (s_axi_wvalid & wready_r) begin
      wready_r <= 1'h0;
      wHeld_r  <= 1'h1;
      wData_r  <= s_axi_wdata;
      wStrb_r  <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld_r  <= 1'h0;
    end else if (bvalid_r & s_axi_bready) begin
      wready_r <= 1'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      bvalid_r <= 1'h0;
      bresp_r  <= `PTA_RESP_OKAY;
    end else if (doWrite) begin
      bvalid_r <= 1'h1;
      bresp_r  <= (wrArea == PTA_AREA_NONE) ? `PTA_RESP_SLVERR : `PTA_RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'h0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctrl_r <= `PTA_CTRL_RST;
      for (int i = 0; i < 16; i++) begin
        mcCfg_r[i] <= `PTA_MCCFG_RST;
      end
    end else if (doWrite && wrArea == PTA_AREA_CTRL) begin
      ctrl_r <= mergeStrb(ctrl_r, wData_r, wStrb_r, `PTA_CTRL_WMASK);
    end else if (doWrite && wrArea == PTA_AREA_MC) begin
      mcCfg_r[awAddr_r[5:2]] <= mergeStrb(mcCfg_r[awAddr_r[5:2]], wData_r, wStrb_r,
                                          `PTA_MCCFG_WMASK);
    end
  end

  pta_cfg_mem #(
    .DEPTH (MEM_DEPTH),
    .AW    (7)
  ) u_mem (
    .clock    (clock),
    .rstn     (rstn),
    .wrEn     (doWrite && wrArea == PTA_AREA_MEM),
    .wrAddr   (awAddr_r[8:2]),
    .wrData   (wData_r),
    .wrStrb   (wStrb_r),
    .rdEn     (s_axi_arvalid & arready_r),
    .rdAddr   (s_axi_araddr[8:2]),
    .rdData   (memRdData),
    .contents (cfgWords)
  );

  // ---- axi4-lite read path: address taken, then one cycle for the memory
  always_ff @(posedge clock) begin
    if (!rstn) begin
      arready_r <= 1'h1;
      rdStage_r <= 1'h0;
      rdArea_r  <= PTA_AREA_NONE;
      rdIdx_r   <= '0;
      rvalid_r  <= 1'h0;
      rdata_r   <= '0;
      rresp_r   <= `PTA_RESP_OKAY;
    end else if (s_axi_arvalid & arready_r) begin
      arready_r <= 1'h0;
      rdStage_r <= 1'h1;
      rdArea_r  <= areaOf(s_axi_araddr);
      rdIdx_r   <= s_axi_araddr[5:2];
    end else if (rdStage_r) begin
      rdStage_r <= 1'h0;
      rvalid_r  <= 1'h1;
      rresp_r   <= (rdArea_r == PTA_AREA_NONE) ? `PTA_RESP_SLVERR : `PTA_RESP_OKAY;
      case (rdArea_r)
        PTA_AREA_CTRL: rdata_r <= ctrl_r;
        PTA_AREA_STAT: rdata_r <= {14'h0, clrB, clrA, macroOut_r};
        PTA_AREA_MC:   rdata_r <= mcCfg_r[rdIdx_r];
        PTA_AREA_MEM:  rdata_r <= memRdData;
        default:       rdata_r <= '0;
      endcase
    end else if (rvalid_r & s_axi_rready) begin
      rvalid_r  <= 1'h0;
      arready_r <= 1'h1;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign macroOut      = macroOut_r;
endmodule : pta_top
`default_nettype wire

// ---- hw/pta_defs.svh ----
// register offsets, field positions, reset values and bus codes of the
// product-term macrocell array; included by every design file that needs them
`ifndef PTA_DEFS_SVH
`define PTA_DEFS_SVH

`define PTA_AW            12
`define PTA_CTRL_OFS      12'h000
`define PTA_STAT_OFS      12'h004
`define PTA_MCCFG_BASE    12'h040
`define PTA_MCCFG_MASK    12'hFC0
`define PTA_PTMEM_BASE    12'h200
`define PTA_PTMEM_MASK    12'hE00

`define PTA_CTRL_RST      32'h0000_0000
`define PTA_CTRL_WMASK    32'h0077_FF3F
`define PTA_MCCFG_RST     32'h0000_0000
`define PTA_MCCFG_WMASK   32'h0000_03FF
`define PTA_SYNC_RST      15'h4000

`define PTA_CTRL_MODE     0
`define PTA_CTRL_RSTEN    1
`define PTA_CTRL_FALLA    2
`define PTA_CTRL_FALLB    3
`define PTA_CTRL_INVCLRA  4
`define PTA_CTRL_INVCLRB  5
`define PTA_CTRL_CLKSRCA  8
`define PTA_CTRL_CLKSRCB  12
`define PTA_CTRL_CLRSRCA  16
`define PTA_CTRL_CLRSRCB  20

`define PTA_MC_SEQ        0
`define PTA_MC_KIND       1
`define PTA_MC_CLKB       3
`define PTA_MC_CLRSEL     4
`define PTA_MC_INVPT1     6
`define PTA_MC_EXP0       7
`define PTA_MC_EXP1       8
`define PTA_MC_CHAIN      9

`define PTA_RESP_OKAY     2'h0
`define PTA_RESP_SLVERR   2'h2

`endif

// ---- hw/pta_pkg.sv ----
// types shared by the product-term macrocell array design files
// assumes nothing of its surroundings
`default_nettype none
package pta_pkg;
  typedef logic [31:0] pta_word_t;

  typedef enum logic [1:0] {
    PTA_KIND_D  = 2'h0,
    PTA_KIND_T  = 2'h1,
    PTA_KIND_JK = 2'h2,
    PTA_KIND_SR = 2'h3
  } pta_kind_e;

  typedef enum logic [4:0] {
    PTA_AREA_CTRL = 5'h01,
    PTA_AREA_STAT = 5'h02,
    PTA_AREA_MC   = 5'h04,
    PTA_AREA_MEM  = 5'h08,
    PTA_AREA_NONE = 5'h10
  } pta_area_e;
endpackage : pta_pkg
`default_nettype wire

// ---- hw/pta_cfg_mem.sv ----
// product-term mask memory: byte-strobed write port, registered read port
// and the whole contents in parallel for the logic array
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module pta_cfg_mem #(
  parameter int DEPTH = 128,
  parameter int AW    = 7
) (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               rstn,
  // write port
  input  wire logic               wrEn,
  input  wire logic [AW-1:0]      wrAddr,
  input  wire pta_pkg::pta_word_t wrData,
  input  wire logic [3:0]         wrStrb,
  // read port
  input  wire logic               rdEn,
  input  wire logic [AW-1:0]      rdAddr,
  output pta_pkg::pta_word_t      rdData,
  // parallel contents
  output logic [DEPTH*32-1:0]     contents
);
  import pta_pkg::*;

  pta_word_t mem_r [DEPTH];
  pta_word_t rdData_r;

  // cleared at reset so that no product term is live before software loads it
  always_ff @(posedge clock) begin
    if (!rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else if (wrEn) begin
      for (int b = 0; b < 4; b++) begin
        if (wrStrb[b]) begin
          mem_r[wrAddr][8*b +: 8] <= wrData[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdData_r <= '0;
    end else if (rdEn) begin
      rdData_r <= mem_r[rdAddr];
    end
  end

  assign rdData = rdData_r;

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      contents[i*32 +: 32] = mem_r[i];
    end
  end
endmodule : pta_cfg_mem
`default_nettype wire

// ---- hw/pta_mc_reg.sv ----
// programmable macrocell register: D, T, JK or SR on a qualified tick,
// with a clear that overrides the tick
// assumes tick and clear are already on the system clock
`timescale 1ns/1ps
`default_nettype none
module pta_mc_reg (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rstn,
  // control
  input  wire logic              tick,
  input  wire pta_pkg::pta_kind_e kind,
  input  wire logic              clear,
  // data
  input  wire logic              primary,
  input  wire logic              secondary,
  output logic                   q
);
  import pta_pkg::*;

  logic q_r;
  logic q_nxt;

  always_comb begin
    q_nxt = q_r;
    if (tick) begin
      case (kind)
        PTA_KIND_D:  q_nxt = primary;
        PTA_KIND_T:  q_nxt = q_r ^ primary;
        PTA_KIND_JK: q_nxt = (primary & ~q_r) | (~secondary & q_r);
        // reset wins when set and reset are both high
        PTA_KIND_SR: q_nxt = secondary ? 1'h0 : (primary | q_r);
        default:     q_nxt = q_r;
      endcase
    end
  end

  // clear ignores tick and enable and holds zero while it stands
  always_ff @(posedge clock) begin
    if (!rstn) begin
      q_r <= 1'h0;
    end else if (clear) begin
      q_r <= 1'h0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;
endmodule : pta_mc_reg
`default_nettype wire

// ---- sim/pta_top_checker.sv ----
// bus handshake and reset assertions for the macrocell array top
// assumes binding to pta_top; it sees the top's ports only
`timescale 1ns/1ps
`default_nettype none
`include "pta_defs.svh"
module pta_top_checker (
  // clock and reset
  input wire logic        clock,
  input wire logic        rstn,
  // bus
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // fabric
  input wire logic [15:0] macroOut
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  wire wGo = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire rGo = s_axi_arvalid && s_axi_arready;
  // the gap between the macrocell table and the mask memory is unmapped
  wire wHole = s_axi_awaddr >= 12'h080 && s_axi_awaddr < 12'h200;
  wire rHole = s_axi_araddr >= 12'h080 && s_axi_araddr < 12'h200;

  AST_RESET: assert property (disable iff (1'b0) !rstn |=> s_axi_awready && s_axi_arready
    && !s_axi_bvalid && !s_axi_rvalid && macroOut == 16'h0000) else $error("bad reset state");
  AST_WR_LAT: assert property (wGo |=> !s_axi_awready && !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer late or early");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer dropped");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
    && s_axi_awready && s_axi_wready) else $error("write not closed");
  AST_RD_LAT: assert property (rGo |=> !s_axi_rvalid ##1 s_axi_rvalid)
    else $error("read answer late or early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read answer dropped");
  AST_RD_HOLE: assert property (rGo && rHole |-> ##2 s_axi_rresp == `PTA_RESP_SLVERR
    && s_axi_rdata == 32'h0000_0000) else $error("unmapped read not refused");
  AST_WR_HOLE: assert property (wGo && wHole |-> ##2 s_axi_bresp == `PTA_RESP_SLVERR)
    else $error("unmapped write not refused");

  COV_WRITE: cover property (wGo ##2 s_axi_bvalid);
  COV_READ: cover property (rGo ##2 s_axi_rvalid);
  COV_OUT: cover property (macroOut != 16'h0000);
endmodule : pta_top_checker

bind pta_top pta_top_checker chk (.*);
`default_nettype wire

// ---- sim/pta_fabric_model.sv ----
// fabric-side driver of block clock, enable, clear and chip reset pins
// assumes the system clock; pins change just after its rising edge
`timescale 1ns/1ps
`default_nettype none
module pta_fabric_model (
  // clock
  input  wire logic  clock,
  // clock sources
  output logic [3:0] dedicatedClock,
  output logic [3:0] globalSignal,
  output logic       localClockA,
  output logic       localClockB,
  // enables, clears and chip reset
  output logic       blockClockEnableA,
  output logic       blockClockEnableB,
  output logic       localClearA,
  output logic       localClearB,
  output logic       chipWideResetN
);
  initial begin
    {dedicatedClock, globalSignal, localClockA, localClockB} = 10'h000;
    {blockClockEnableA, blockClockEnableB, localClearA, localClearB} = 4'h0;
    chipWideResetN = 1'b1;
  end
  // clocks stand low between pulses; each level outlasts the resync stages
  task automatic pulse(input logic useB);
    @(posedge clock);
    localClockA <= !useB;
    localClockB <= useB;
    repeat (4) @(posedge clock);
    localClockA <= 1'b0;
    localClockB <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : pulse
  task automatic pins(input logic enA, input logic enB, input logic clrA, input logic rstN);
    @(posedge clock);
    blockClockEnableA <= enA;
    blockClockEnableB <= enB;
    localClearA <= clrA;
    chipWideResetN <= rstN;
  endtask : pins
endmodule : pta_fabric_model
`default_nettype wire

// ---- sim/test_product_term_macrocell_array.sv ----
// directed bench: bus writes configure macrocells, fabric pins exercise them
// assumes pta_top with default parameters and the fabric model beside it
`timescale 1ns/1ps
`default_nettype none
`include "pta_defs.svh"
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module test_product_term_macrocell_array;
  import pta_pkg::*;
  localparam logic [1:0] OK = `PTA_RESP_OKAY;
  localparam logic [1:0] SE = `PTA_RESP_SLVERR;
  logic            clock = 1'b0;
  logic            rstn = 1'b0;
  logic [11:0]     s_axi_awaddr;
  logic [11:0]     s_axi_araddr;
  pta_word_t       s_axi_wdata;
  logic [3:0]      s_axi_wstrb;
  logic            s_axi_awvalid;
  logic            s_axi_wvalid;
  logic            s_axi_bready;
  logic            s_axi_arvalid;
  logic            s_axi_rready;
  logic [31:0]     fabricIn;
  logic            s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]      s_axi_bresp, s_axi_rresp;
  pta_word_t       s_axi_rdata;
  logic [15:0]     macroOut;
  wire logic [3:0] dedicatedClock, globalSignal;
  wire logic       localClockA, localClockB, blockClockEnableA, blockClockEnableB;
  wire logic       localClearA, localClearB, chipWideResetN;
  int              fail_count = 0;
  int              comparisons = 0;
  int              cycles = 0;

  pta_fabric_model fab (.*);
  pta_top uut (.*);

  initial forever #10 clock = ~clock;

  // far above the directed run of a few hundred cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input pta_word_t v, input logic [1:0] er);
    int t;
    t = 0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      t++;
    end while (!s_axi_bvalid && t < 50);
    s_axi_bready <= 1'b0;
    `CHK("bvalid", 1'b1, s_axi_bvalid);
    `CHK("bresp", er, s_axi_bresp);
  endtask : wr

  task automatic rd(input logic [11:0] a, input pta_word_t ed, input logic [1:0] er);
    int t;
    t = 0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      t++;
    end while (!s_axi_rvalid && t < 50);
    s_axi_rready <= 1'b0;
    `CHK("rdata", ed, s_axi_rdata);
    `CHK("rresp", er, s_axi_rresp);
  endtask : rd

  // outputs settle well within six cycles, resync stages included
  task automatic outIs(input logic [15:0] e);
    repeat (6) @(posedge clock);
    `CHK("macroOut", e, macroOut);
  endtask : outIs

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, fabricIn} <= '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
    s_axi_wstrb <= 4'hF;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    rd(12'h000, 32'h0, OK);
    // m0 = in0, m2 = m0 fed back, m3 = !in0, m1 = inverted empty term, m4 lends in1 to m5
    wr(12'h200, 32'h1, OK);
    wr(12'h248, 32'h1, OK);
    wr(12'h264, 32'h1, OK);
    wr(12'h280, 32'h2, OK);
    wr(12'h044, 32'h40, OK);
    wr(12'h050, 32'h80, OK);
    wr(12'h054, 32'h200, OK);
    @(posedge clock) fabricIn <= 32'h1;
    outIs(16'h0000);
    wr(12'h000, 32'hFFFF_FFFF, OK);
    rd(12'h000, `PTA_CTRL_WMASK, OK);
    // only byte 0 written: the other bytes keep their stored value
    s_axi_wstrb <= 4'h1;
    wr(12'h000, 32'h0000_0000, OK);
    s_axi_wstrb <= 4'hF;
    rd(12'h000, `PTA_CTRL_WMASK & 32'hFFFF_FF00, OK);
    wr(12'h100, 32'h1, SE);
    rd(12'h100, 32'h0, SE);
    wr(12'h000, 32'h0004_8801, OK);
    outIs(16'h0007);
    @(posedge clock) fabricIn <= 32'h2;
    outIs(16'h002A);
    @(posedge clock) fabricIn <= 32'h0;
    outIs(16'h000A);
    rd(12'h004, 32'h0000_000A, OK);
    // m0 as D on clock A
    wr(12'h040, 32'h1, OK);
    fab.pins(1'b1, 1'b0, 1'b0, 1'b1);
    @(posedge clock) fabricIn <= 32'h1;
    fab.pulse(1'b0);
    outIs(16'h0007);
    @(posedge clock) fabricIn <= 32'h0;
    fab.pins(1'b0, 1'b0, 1'b0, 1'b1);
    fab.pulse(1'b0);
    outIs(16'h000F);
    fab.pulse(1'b1);
    outIs(16'h000F);
    fab.pins(1'b1, 1'b0, 1'b0, 1'b1);
    fab.pulse(1'b0);
    outIs(16'h000A);
    // m0 as T on clock B
    wr(12'h040, 32'hB, OK);
    fab.pins(1'b0, 1'b1, 1'b0, 1'b1);
    @(posedge clock) fabricIn <= 32'h1;
    fab.pulse(1'b1);
    outIs(16'h0007);
    fab.pulse(1'b1);
    outIs(16'h0002);
    // m0 as D on clock A with clear A
    wr(12'h040, 32'h11, OK);
    fab.pins(1'b1, 1'b1, 1'b0, 1'b1);
    fab.pulse(1'b0);
    outIs(16'h0007);
    fab.pins(1'b1, 1'b1, 1'b1, 1'b1);
    outIs(16'h0002);
    fab.pulse(1'b0);
    outIs(16'h0002);
    fab.pins(1'b1, 1'b1, 1'b0, 1'b1);
    outIs(16'h0002);
    fab.pulse(1'b0);
    outIs(16'h0007);
    wr(12'h000, 32'h0004_8811, OK);
    outIs(16'h0002);
    wr(12'h000, 32'h0004_8803, OK);
    fab.pulse(1'b0);
    outIs(16'h0007);
    fab.pins(1'b1, 1'b1, 1'b0, 1'b0);
    repeat (6) @(posedge clock);
    `CHK("chip reset", 1'b0, macroOut[0]);
    fab.pins(1'b1, 1'b1, 1'b0, 1'b1);
    fab.pulse(1'b0);
    outIs(16'h0007);
    // clear B from an idle global signal, inverted, picked by m0
    wr(12'h000, 32'h0000_8821, OK);
    wr(12'h040, 32'h21, OK);
    outIs(16'h0002);
    rd(12'h004, 32'h0002_0002, OK);
    end_of_test();
  end
endmodule : test_product_term_macrocell_array
`default_nettype wire
